// ==== hw/sceld_cfg.svh ====
// Purpose: constants of the serial configuration memory loader
// Assumes: 200 MHz core clock, four-wire serial memory, 16-bit words
// Notes:   offsets none; only timing, command and field values
//
// Overview of operation
// RULE_01: With the presence strap high the loader reads its configuration from the external memory over the serial link.
// RULE_02: With the presence strap low or open no serial load is ever started.
// RULE_03: A dedicated select output selects the memory during each configuration access.
// RULE_04: The loader drives serial data on its data output, which the memory takes as its data input.
// RULE_05: With bus speed 2'b11 (25 MHz bus) the serial clock has a 4 us cycle during the load.
// RULE_06: With bus speed 2'b00 (125 MHz bus) the serial clock has an 800 ns cycle during the load.
// RULE_07: With the memory present the loader samples its serial input, driven by the memory's data output.
// RULE_08: With no memory the serial input level is caught as a strap: low gives 8-bit, high 16-bit bus mode.
// RULE_09: Outside an active load the select stays low and the serial clock stays idle low.
`ifndef SCELD_CFG_SVH
`define SCELD_CFG_SVH

`define SCELD_CLK_PERIOD_NS  5
`define SCELD_SK_SLOW_NS     4000
`define SCELD_SK_FAST_NS     800
`define SCELD_HALF_SLOW      ((`SCELD_SK_SLOW_NS / `SCELD_CLK_PERIOD_NS) / 2)
`define SCELD_HALF_FAST      ((`SCELD_SK_FAST_NS / `SCELD_CLK_PERIOD_NS) / 2)
`define SCELD_SPEED_SLOW     2'h3
`define SCELD_SPEED_FAST     2'h0
`define SCELD_READ_OP        3'h6
`define SCELD_CMD_BITS       5'h09
`define SCELD_WORD_BITS      5'h10
`define SCELD_LAST_ADDR      6'h07
`define SCELD_SETTLE_LAST    2'h3

`endif

// ==== hw/sceld_pkg.sv ====
// Purpose: types of the serial configuration memory loader
// Assumes: nothing beyond the cfg header
// Notes:   state structs are registered whole by one always_ff
package sceld_pkg;

    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_DISABLED,
        ST_START,
        ST_SEND,
        ST_READ,
        ST_GAP,
        ST_DONE
    } sceld_state_e;

    typedef struct packed {
        logic [8:0] cnt;
        logic       sk;
        logic       rise;
        logic       fall;
    } sceld_gen_s;

    typedef struct packed {
        sceld_state_e state;
        logic [1:0]   settle;
        logic [4:0]   bits;
        logic [15:0]  shreg;
        logic [5:0]   addr;
        logic         cs;
        logic         dout;
        logic [15:0]  word;
        logic [5:0]   waddr;
        logic         wvalid;
        logic         done;
        logic         used;
        logic         bus16;
        logic         strap_m;
        logic         strap_s;
        logic         sin_m;
        logic         sin_s;
    } sceld_main_s;

endpackage : sceld_pkg

// ==== hw/sceld_sk_if.sv ====
// Purpose: link between loader and its serial clock divider
// Assumes: one clock domain
// Notes:   rise and fall pulse in the cycle the new level shows
`timescale 1ns/1ps
interface sceld_sk_if;
    logic       run;
    logic [8:0] half_m1;
    logic       sk;
    logic       rise;
    logic       fall;

    modport gen  (input run, input half_m1, output sk, output rise,
                  output fall);
    modport user (output run, output half_m1, input sk, input rise,
                  input fall);
endinterface : sceld_sk_if

// ==== hw/sceld_sk_gen.sv ====
// Purpose: serial clock divider for the configuration memory link
// Assumes: half_m1 stable while run is high
// Notes:   each level lasts half_m1 + 1 core cycles
`timescale 1ns/1ps
module sceld_sk_gen
    import sceld_pkg::*;
(
    input  wire logic  core_clk,
    input  wire logic  reset,
    sceld_sk_if.gen    skl
);
    sceld_gen_s s;
    sceld_gen_s next_s;

    always_comb begin
        next_s      = s;
        next_s.rise = 1'b0;
        next_s.fall = 1'b0;
        if (!skl.run) begin
            // idle low, counter parked so each run starts on a full half
            next_s.cnt = 9'h000; // RULE_09
            next_s.sk  = 1'b0;
        end else if (s.cnt == skl.half_m1) begin
            next_s.cnt  = 9'h000;
            next_s.sk   = !s.sk;
            next_s.rise = !s.sk;
            next_s.fall = s.sk;
        end else begin
            next_s.cnt = s.cnt + 9'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign skl.sk   = s.sk;
    assign skl.rise = s.rise;
    assign skl.fall = s.fall;

    stop_idle_a: assert property ( // RULE_09
        @(posedge core_clk) disable iff (reset) !skl.run |=> !s.sk)
        else $error("serial clock not idle");
endmodule : sceld_sk_gen

// ==== hw/sceld_loader.sv ====
// Purpose: loads configuration words from an optional serial memory
// Assumes: strap and serial input are asynchronous pins
// Notes:   reads words 0..7 with a read command, one word per select
`timescale 1ns/1ps
`include "sceld_cfg.svh"
module sceld_loader
    import sceld_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        cfg_mem_present_strap,
    input  wire logic [1:0]  internal_bus_speed_control,
    input  wire logic        cfg_mem_serial_in,
    output logic             cfg_mem_select,
    output logic             cfg_mem_serial_clock,
    output logic             cfg_mem_serial_out,
    output logic [15:0]      cfg_word_data,
    output logic [5:0]       cfg_word_addr,
    output logic             cfg_word_valid,
    output logic             load_done,
    output logic             cfg_mem_used,
    output logic             host_bus_16bit
);
    localparam int HALF_SLOW_M1 = `SCELD_HALF_SLOW - 1;
    localparam int HALF_FAST_M1 = `SCELD_HALF_FAST - 1;
    // held as a vector so single opcode bits can be picked
    localparam logic [2:0] READ_OP = `SCELD_READ_OP;

    // ---------------------------------------------------------------
    // speed decode
    // ---------------------------------------------------------------
    // codes 01 and 10 get the slow clock: safe for any bus speed
    function automatic logic [8:0] half_of(input logic [1:0] spd);
        if (spd == `SCELD_SPEED_FAST) begin
            half_of = 9'(HALF_FAST_M1);
        end else begin
            half_of = 9'(HALF_SLOW_M1);
        end
    endfunction : half_of

    sceld_main_s s;
    sceld_main_s next_s;
    sceld_sk_if  skl ();

    sceld_sk_gen u_gen (
        .core_clk (core_clk),
        .reset    (reset),
        .skl      (skl)
    );

    assign skl.half_m1 = half_of(internal_bus_speed_control); // RULE_05 RULE_06
    assign skl.run     = (s.state == ST_SEND) || (s.state == ST_READ) ||
                         (s.state == ST_GAP);

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        next_s         = s;
        next_s.wvalid  = 1'b0;
        // two flops on each pin before anything reads them
        next_s.strap_m = cfg_mem_present_strap;
        next_s.strap_s = s.strap_m;
        next_s.sin_m   = cfg_mem_serial_in;
        next_s.sin_s   = s.sin_m;
        case (s.state)
            ST_SETTLE: begin
                // wait for the synchronisers to fill before trusting straps
                next_s.settle = s.settle + 2'h1;
                if (s.settle == `SCELD_SETTLE_LAST) begin
                    if (s.strap_s) begin
                        next_s.used  = 1'b1; // RULE_01
                        next_s.state = ST_START;
                    end else begin
                        next_s.bus16 = s.sin_s; // RULE_08
                        next_s.done  = 1'b1;
                        next_s.state = ST_DISABLED; // RULE_02
                    end
                end
            end
            ST_DISABLED: begin
                next_s.cs = 1'b0; // RULE_02
            end
            ST_START: begin
                next_s.cs    = 1'b1; // RULE_03
                // first opcode bit stands now, the rest follow sk falls
                next_s.dout  = READ_OP[2]; // RULE_04
                next_s.shreg = {READ_OP[1:0], s.addr, 8'h00};
                next_s.bits  = 5'h00;
                next_s.state = ST_SEND;
            end
            ST_SEND: begin
                if (skl.rise) begin
                    next_s.bits = s.bits + 5'h01;
                end else if (skl.fall) begin
                    if (s.bits == `SCELD_CMD_BITS) begin
                        next_s.bits  = 5'h00;
                        next_s.dout  = 1'b0;
                        next_s.state = ST_READ;
                    end else begin
                        next_s.dout  = s.shreg[15]; // RULE_04
                        next_s.shreg = {s.shreg[14:0], 1'b0};
                    end
                end
            end
            ST_READ: begin
                if (skl.rise) begin
                    next_s.shreg = {s.shreg[14:0], s.sin_s}; // RULE_07
                    next_s.bits  = s.bits + 5'h01;
                end else if (skl.fall && s.bits == `SCELD_WORD_BITS) begin
                    next_s.word   = s.shreg;
                    next_s.waddr  = s.addr;
                    next_s.wvalid = 1'b1;
                    next_s.cs     = 1'b0;
                    next_s.state  = ST_GAP;
                end
            end
            ST_GAP: begin
                // one full clock period with select low between words
                if (skl.fall) begin
                    if (s.addr == `SCELD_LAST_ADDR) begin
                        next_s.done  = 1'b1;
                        next_s.state = ST_DONE;
                    end else begin
                        next_s.addr  = s.addr + 6'h01;
                        next_s.state = ST_START;
                    end
                end
            end
            ST_DONE: begin
                next_s.cs   = 1'b0; // RULE_09
                next_s.dout = 1'b0;
            end
            default: begin
                next_s.state = ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cfg_mem_select       = s.cs;
    assign cfg_mem_serial_clock = skl.sk;
    assign cfg_mem_serial_out   = s.dout;
    assign cfg_word_data        = s.word;
    assign cfg_word_addr        = s.waddr;
    assign cfg_word_valid       = s.wvalid;
    assign load_done            = s.done;
    assign cfg_mem_used         = s.used;
    assign host_bus_16bit       = s.bus16;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [8:0] hold;

    always_ff @(posedge core_clk) begin
        if (reset || !skl.run || skl.rise || skl.fall) begin
            hold <= 9'h000;
        end else begin
            hold <= hold + 9'h001;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence decide_present;
        s.state == ST_SETTLE && s.settle == `SCELD_SETTLE_LAST && s.strap_s;
    endsequence

    sequence select_opens;
        s.state == ST_START ##1 cfg_mem_select && s.state == ST_SEND;
    endsequence

    sequence word_complete;
        s.state == ST_READ && skl.fall && s.bits == `SCELD_WORD_BITS;
    endsequence

    load_start_a: assert property (decide_present |=> select_opens) // RULE_01
        else $error("present memory not selected");
    no_load_a: assert property (s.state == ST_DISABLED |-> // RULE_02
        !cfg_mem_select && !skl.run)
        else $error("load ran without memory");
    select_on_a: assert property (s.state == ST_SEND || // RULE_03
        s.state == ST_READ |-> cfg_mem_select)
        else $error("select dropped during access");
    data_hold_a: assert property (cfg_mem_serial_clock && // RULE_04
        $past(cfg_mem_serial_clock) |-> $stable(cfg_mem_serial_out))
        else $error("data moved while clock high");
    slow_half_a: assert property (skl.fall && // RULE_05
        internal_bus_speed_control == `SCELD_SPEED_SLOW |->
        hold == 9'(HALF_SLOW_M1))
        else $error("slow clock half period wrong");
    fast_half_a: assert property (skl.fall && // RULE_06
        internal_bus_speed_control == `SCELD_SPEED_FAST |->
        hold == 9'(HALF_FAST_M1))
        else $error("fast clock half period wrong");
    sample_in_a: assert property (s.state == ST_READ && // RULE_07
        skl.rise |=> s.shreg[0] == $past(s.sin_s))
        else $error("serial input not sampled");
    word_out_a: assert property (word_complete |=> // RULE_07
        cfg_word_valid && !cfg_mem_select && cfg_word_data == $past(s.shreg))
        else $error("word not handed over");
    valid_pulse_a: assert property (cfg_word_valid |=> // RULE_07
        !cfg_word_valid)
        else $error("word strobe longer than one cycle");
    strap_mode_a: assert property (s.state == ST_SETTLE && // RULE_08
        s.settle == `SCELD_SETTLE_LAST && !s.strap_s |=>
        host_bus_16bit == $past(s.sin_s) && load_done)
        else $error("bus width strap not caught");
    idle_link_a: assert property (s.state == ST_DONE || // RULE_09
        s.state == ST_SETTLE |-> !cfg_mem_select && !cfg_mem_serial_clock)
        else $error("link active outside load");
    gap_idle_a: assert property (s.state == ST_GAP |-> // RULE_09
        !cfg_mem_select)
        else $error("select high between words");
endmodule : sceld_loader

// ==== test/sceld_mem_model.sv ====
// Purpose: behavioural serial configuration memory for the loader bench
// Assumes: read command 1,1,0 then six address bits, MSB first
// Notes:   released data line reads low, the output is gated to zero while drive is low
`timescale 1ns/1ps
module sceld_mem_model (
    input  wire logic mem_select,
    input  wire logic mem_clock,
    input  wire logic mem_din,
    output logic      mem_dout
);
    logic [4:0]  n     = 5'h00;
    logic [8:0]  cmd   = 9'h000;
    logic [15:0] sh    = 16'h0000;
    logic        drive = 1'b0;
    logic        dbit  = 1'b0;

    assign mem_dout = drive & dbit;

    always @(posedge mem_clock) begin
        if (mem_select && n < 5'h09) begin
            cmd = {cmd[7:0], mem_din};
            n = n + 5'h01;
            if (n == 5'h09) begin
                drive = 1'b1;
                // dummy zero ahead of the data bits
                dbit = 1'b0;
                // a wrong opcode returns zeros, so the bench sees it
                sh = (cmd[8:6] == 3'h6) ?
                     16'hA50F ^ {cmd[5:0], cmd[3:0], cmd[5:0]} : 16'h0000;
            end
        end
    end

    always @(negedge mem_clock) begin
        if (mem_select && drive) begin
            dbit = sh[15];
            sh = {sh[14:0], 1'b0};
        end
    end

    always @(negedge mem_select) begin
        n = 5'h00;
        drive = 1'b0;
    end
endmodule : sceld_mem_model

// ==== test/tb.sv ====
// Purpose: self-checking bench of the configuration memory loader
// Assumes: inputs change on the falling clock edge
// Notes:   slow clock is only timed, a full slow load runs too long
`timescale 1ns/1ps
module tb;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic        strap    = 1'b0;
    logic [1:0]  speed    = 2'h0;
    logic        strap_si = 1'b0;
    wire         mem_do;
    wire         serial_in;
    logic        sel, sk, sout, wvalid, done, used, bus16;
    logic [15:0] wdata;
    logic [5:0]  waddr;
    int          errors    = 0;
    int          tests_run = 0;

    // with no memory fitted the pin carries the bus width strap
    assign serial_in = strap ? mem_do : strap_si;
    always #2.5 core_clk = ~core_clk;

    sceld_loader u_sceld_loader (
        .core_clk                   (core_clk),
        .reset                      (reset),
        .cfg_mem_present_strap      (strap),
        .internal_bus_speed_control (speed),
        .cfg_mem_serial_in          (serial_in),
        .cfg_mem_select             (sel),
        .cfg_mem_serial_clock       (sk),
        .cfg_mem_serial_out         (sout),
        .cfg_word_data              (wdata),
        .cfg_word_addr              (waddr),
        .cfg_word_valid             (wvalid),
        .load_done                  (done),
        .cfg_mem_used               (used),
        .host_bus_16bit             (bus16)
    );

    sceld_mem_model u_sceld_mem_model (
        .mem_select (sel),
        .mem_clock  (sk),
        .mem_din    (sout),
        .mem_dout   (mem_do)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic conclude;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic restart(input logic s, input logic [1:0] sp,
                           input logic si);
        @(negedge core_clk);
        reset = 1'b1;
        strap = s;
        speed = sp;
        strap_si = si;
        repeat (10) @(negedge core_clk);
        chk({15'h0000, sel}, 16'h0000, "select in reset");
        reset = 1'b0;
    endtask : restart

    task automatic wait_rise(output logic [15:0] cyc);
        logic prev;
        cyc = 16'h0000;
        repeat (2000) begin
            prev = sk;
            @(negedge core_clk);
            cyc = cyc + 16'h0001;
            if (prev === 1'b0 && sk === 1'b1)
                return;
        end
        cyc = 16'hFFFF;
    endtask : wait_rise

    task automatic quiet(input int n);
        logic moved;
        moved = 1'b0;
        repeat (n) begin
            @(negedge core_clk);
            if (sk !== 1'b0 || sel !== 1'b0)
                moved = 1'b1;
        end
        chk({15'h0000, moved}, 16'h0000, "link idle");
    endtask : quiet

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_period(input logic [1:0] sp, input logic [15:0] exp);
        logic [15:0] c;
        restart(1'b1, sp, 1'b0);
        wait_rise(c);
        wait_rise(c);
        chk(c, exp, "sk period");
        chk({15'h0000, sel}, 16'h0001, "select in load");
    endtask : t_period

    task automatic t_load;
        int i;
        int k;
        restart(1'b1, 2'h0, 1'b1);
        for (i = 0; i < 8; i++) begin
            k = 0;
            while (wvalid !== 1'b1 && k < 6000) begin
                @(negedge core_clk);
                k++;
            end
            chk({15'h0000, wvalid}, 16'h0001, "word strobe");
            chk({10'h000, waddr}, i[15:0], "word address");
            chk(wdata, 16'hA50F ^ {i[5:0], i[3:0], i[5:0]},
                "word data");
            @(negedge core_clk);
        end
        repeat (400) @(negedge core_clk);
        chk({12'h000, done, used, bus16, sel}, 16'h000C,
            "load finished");
        quiet(400);
    endtask : t_load

    task automatic t_absent(input logic si);
        restart(1'b0, 2'h0, si);
        repeat (8) @(negedge core_clk);
        // a late change of the pin must not be caught
        strap_si = ~si;
        quiet(400);
        chk({12'h000, done, used, bus16, sel},
            {12'h000, 1'b1, 1'b0, si, 1'b0}, "strap mode");
    endtask : t_absent

    initial begin
        t_period(2'h0, 16'h00A0);
        t_period(2'h3, 16'h0320);
        t_period(2'h2, 16'h0320);
        t_load();
        t_absent(1'b1);
        t_absent(1'b0);
        conclude();
    end

    // run needs about 38k cycles
    initial begin
        #400000;
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
endmodule : tb
